// [edwc_pkg.sv]
// Constants shared by the data EEPROM write-control block and its memory.
// Assumes a 125 MHz core clock and a 32-bit classic Wishbone register bus.

package edwc_pkg;

  // ----------------------------------------------------------------------
  // Register byte addresses on the Wishbone bus
  // ----------------------------------------------------------------------
  localparam logic [7:0] OFS_ADDR_HIGH = 8'h00;
  localparam logic [7:0] OFS_ADDR_LOW = 8'h04;
  localparam logic [7:0] OFS_DATA_BYTE = 8'h08;
  localparam logic [7:0] OFS_UNLOCK_KEY = 8'h0C;
  localparam logic [7:0] OFS_ACCESS_CTRL = 8'h10;
  localparam logic [7:0] OFS_PRIORITY_TWO = 8'h14;
  localparam logic [7:0] OFS_FLAGS_TWO = 8'h18;
  localparam logic [7:0] OFS_ENABLES_TWO = 8'h1C;
  localparam logic [7:0] OFS_IRQ_GLOBAL = 8'h20;

  // ----------------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------------
  localparam int CTL_SELECT_BIT = 7;
  localparam int CTL_CFGSEL_BIT = 6;
  localparam int CTL_ROWERASE_BIT = 4;
  localparam int CTL_WERR_BIT = 3;
  localparam int CTL_WRITE_ENABLE_BIT_BIT = 2;
  localparam int CTL_WR_BIT = 1;
  localparam int CTL_RD_BIT = 0;
  localparam int DONE_BIT = 4;
  localparam int GIE_HIGH_BIT = 7;
  localparam int GIE_LOW_BIT = 6;
  localparam int ADDR_W = 10;
  localparam int ADDR_HIGH_W = 2;
  localparam int MEM_DEPTH = 1024;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [7:0] KEY_FIRST = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'hAA;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_FREQ_MHZ = 125;
  localparam int WRITE_TIME_US = 4000;
  localparam int PWRT_TIME_US = 65600;
  localparam int WRITE_CYCLES = WRITE_TIME_US * CLK_FREQ_MHZ;
  localparam int PWRT_CYCLES = PWRT_TIME_US * CLK_FREQ_MHZ;

  // ----------------------------------------------------------------------
  // State encodings
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {KEY_IDLE, KEY_HALF, KEY_ARMED} edwc_key_e;
  typedef enum logic [1:0] {WR_IDLE, WR_ERASE, WR_PROG} edwc_wr_e;

endpackage : edwc_pkg

// [edwc_mem.sv]
// Byte-wide nonvolatile array model: one shared port, registered read data.
// Assumes the controller never reads and writes in the same cycle.
`timescale 1ns/1ps
`default_nettype none

module edwc_mem
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Access port
  input wire logic we,
  input wire logic re,
  input wire logic [edwc_pkg::ADDR_W-1:0] addr,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata_q
);

  // ----------------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------------
  logic [7:0] cells [edwc_pkg::MEM_DEPTH];

  // Array cells carry no reset, as a real nonvolatile array keeps its data.
  always_ff @(posedge clk)
  begin
    if (we)
    begin
      cells[addr] <= wdata;
    end
  end

  // Read data is registered so the controller sees it one edge later.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rdata_q <= edwc_pkg::BYTE_RESET;
    end
    else if (re)
    begin
      rdata_q <= cells[addr];
    end
  end

endmodule : edwc_mem
`default_nettype wire

// [edwc_ctrl.sv]
// Data EEPROM write control: register file, unlock sequence, self-timed
// erase/write, power-up write block and protected external access port.
// Assumes a classic Wishbone master on CORE_CLK and asynchronous pins
// for the external programming port and the code-protect strap.
//
// Design decisions made here: register access over Wishbone and the address map.
`timescale 1ns/1ps
`default_nettype none

module edwc_ctrl
#(
  parameter int unsigned WRITE_CYCLES = edwc_pkg::WRITE_CYCLES,
  parameter int unsigned PWRT_CYCLES = edwc_pkg::PWRT_CYCLES
)
(
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic RST,
  // Wishbone slave
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  // Interrupt requests
  output logic IRQ_HIGH,
  output logic IRQ_LOW,
  // External programming port and code-protect strap
  input wire logic CODE_PROTECT,
  input wire logic EXT_RD,
  input wire logic EXT_WR,
  input wire logic [9:0] EXT_ADDR,
  input wire logic [7:0] EXT_WDATA,
  output logic [7:0] EXT_RDATA,
  output logic EXT_DENIED,
  output logic WRITE_BUSY
);

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  localparam int unsigned PHASE_CYCLES =
    (WRITE_CYCLES > 32'd1) ? WRITE_CYCLES / 32'd2 : 32'd1;
  logic ack_q, req, wr_req, rd_req, busy, start, wr_try, ctl_wr;
  logic [1:0] addr_high_q;
  logic [7:0] addr_low_q, data_q, rd_mux;
  logic sel_q, cfgsel_q, rowerase_q, werr_q, write_enable_bit_q, wr_q, rd_q;
  logic done_q, done_en_q, done_prio_q, gie_high_q, gie_low_q;
  edwc_pkg::edwc_key_e key_q;
  edwc_pkg::edwc_wr_e wst_q;
  logic [31:0] wcnt_q, pwrt_cnt_q;
  logic pwrt_done_q, done_pulse, first_q, inflight_q;
  logic [9:0] waddr_q, mem_addr;
  logic [7:0] wdata_q, mem_wdata, mem_rdata;
  logic mem_we, mem_re, core_rd_go, ext_rd_go, ext_wr_go, ext_pend_q;
  logic [20:0] s1_q, s2_q;
  logic [1:0] s3_q;
  logic ext_rd_rise, ext_wr_rise, prot_s;

  // Write hit on one register offset.
  function automatic logic hit(input logic [7:0] adr, input logic [7:0] ofs,
                               input logic go);
    hit = go && (adr == ofs);
  endfunction : hit

  // ----------------------------------------------------------------------
  // Wishbone slave: answers every access one cycle after it is seen
  // ----------------------------------------------------------------------
  assign req = WB_CYC_I && WB_STB_I && !ack_q;
  assign wr_req = req && WB_WE_I && WB_SEL_I[0];
  assign rd_req = req && !WB_WE_I;
  assign busy = (wst_q != edwc_pkg::WR_IDLE);
  assign ctl_wr = hit(WB_ADR_I, edwc_pkg::OFS_ACCESS_CTRL, wr_req);

  // Ack is one cycle wide; the master drops its strobe after seeing it.
  always_ff @(posedge CORE_CLK or posedge RST)
  begin
    if (RST)
    begin
      ack_q <= 1'b0;
    end
    else
    begin
      ack_q <= req;
    end
  end

  // Read multiplexer; unmapped offsets and absent bits read as zero.
  always_comb
  begin
    rd_mux = 8'h00;
    case (WB_ADR_I)
      edwc_pkg::OFS_ADDR_HIGH: rd_mux = {6'h00, addr_high_q};
      edwc_pkg::OFS_ADDR_LOW: rd_mux = addr_low_q;
      edwc_pkg::OFS_DATA_BYTE: rd_mux = data_q;
      edwc_pkg::OFS_UNLOCK_KEY: rd_mux = 8'h00;
      edwc_pkg::OFS_ACCESS_CTRL: rd_mux = {sel_q, cfgsel_q, 1'b0, rowerase_q,
                                    werr_q, write_enable_bit_q, wr_q, rd_q};
      edwc_pkg::OFS_PRIORITY_TWO: rd_mux = {3'h0, done_prio_q, 4'h0};
      edwc_pkg::OFS_FLAGS_TWO: rd_mux = {3'h0, done_q, 4'h0};
      edwc_pkg::OFS_ENABLES_TWO: rd_mux = {3'h0, done_en_q, 4'h0};
      edwc_pkg::OFS_IRQ_GLOBAL: rd_mux = {gie_high_q, gie_low_q, 6'h00};
      default: rd_mux = 8'h00;
    endcase
  end

  // Read data is captured on the same edge that raises ack.
  always_ff @(posedge CORE_CLK or posedge RST)
  begin
    if (RST)
    begin
      WB_DAT_O <= 32'h0000_0000;
      WB_ACK_O <= 1'b0;
    end
    else
    begin
      WB_ACK_O <= req;
      if (rd_req)
      begin
        WB_DAT_O <= {24'h00_0000, rd_mux};
      end
    end
  end

  // ----------------------------------------------------------------------
  // Pin synchronisers and power-up timer
  // ----------------------------------------------------------------------
  // Ext address and data are assumed steady around their strobe edge.
  always_ff @(posedge CORE_CLK or posedge RST)
  begin
    if (RST)
    begin
      s1_q <= 21'h00_0000;
      s2_q <= 21'h00_0000;
      s3_q <= 2'h0;
    end
    else
    begin
      s1_q <= {CODE_PROTECT, EXT_RD, EXT_WR, EXT_ADDR, EXT_WDATA};
      s2_q <= s1_q;
      s3_q <= s2_q[19:18];
    end
  end
  assign prot_s = s2_q[20];
  assign ext_rd_rise = s2_q[19] && !s3_q[1];
  assign ext_wr_rise = s2_q[18] && !s3_q[0];

  // Writes stay blocked until the timer has run out after reset.
  always_ff @(posedge CORE_CLK or posedge RST)
  begin
    if (RST)
    begin
      pwrt_cnt_q <= 32'h0000_0000;
      pwrt_done_q <= 1'b0;
    end
    else if (!pwrt_done_q)
    begin
      pwrt_cnt_q <= pwrt_cnt_q + 32'h0000_0001;
      pwrt_done_q <= (pwrt_cnt_q + 32'h0000_0001 >= PWRT_CYCLES);
    end
  end

  // ----------------------------------------------------------------------
  // Unlock sequence and write start
  // ----------------------------------------------------------------------
  assign wr_try = ctl_wr && WB_DAT_I[edwc_pkg::CTL_WR_BIT] && !busy;
  // Old write_enable_bit_q is used, so WRITE_ENABLE_BIT and WR in one access start only if the bit was already set.
  assign start = wr_try && (key_q == edwc_pkg::KEY_ARMED) && write_enable_bit_q &&
                 pwrt_done_q && (WB_DAT_I[7:6] == 2'b00);
  // A read asked for in the same access as a write start is dropped, so the
  // data register cannot change under a running core write.
  assign core_rd_go = ctl_wr && !busy && !start &&
                      WB_DAT_I[edwc_pkg::CTL_RD_BIT] &&
                      (WB_DAT_I[7:6] == 2'b00);
  assign ext_rd_go = ext_rd_rise && !prot_s && !busy && !core_rd_go;
  assign ext_wr_go = ext_wr_rise && !prot_s && !busy && !start &&
                     pwrt_done_q;

  // Any write to the control register consumes or breaks the sequence.
  always_ff @(posedge CORE_CLK or posedge RST)
  begin
    if (RST)
    begin
      key_q <= edwc_pkg::KEY_IDLE;
    end
    else if (hit(WB_ADR_I, edwc_pkg::OFS_UNLOCK_KEY, wr_req))
    begin
      if (key_q == edwc_pkg::KEY_IDLE && WB_DAT_I[7:0] == edwc_pkg::KEY_FIRST)
      begin
        key_q <= edwc_pkg::KEY_HALF;
      end
      else if (key_q == edwc_pkg::KEY_HALF &&
               WB_DAT_I[7:0] == edwc_pkg::KEY_SECOND)
      begin
        key_q <= edwc_pkg::KEY_ARMED;
      end
      else
      begin
        key_q <= edwc_pkg::KEY_IDLE;
      end
    end
    else if (ctl_wr)
    begin
      key_q <= edwc_pkg::KEY_IDLE;
    end
  end

  // ----------------------------------------------------------------------
  // Self-timed erase then program
  // ----------------------------------------------------------------------
  always_ff @(posedge CORE_CLK or posedge RST)
  begin
    if (RST)
    begin
      wst_q <= edwc_pkg::WR_IDLE;
      wcnt_q <= 32'h0000_0000;
      waddr_q <= 10'h000;
      wdata_q <= edwc_pkg::BYTE_RESET;
    end
    else
    begin
      case (wst_q)
        edwc_pkg::WR_IDLE:
        begin
          wcnt_q <= 32'h0000_0000;
          if (start)
          begin
            wst_q <= edwc_pkg::WR_ERASE;
            waddr_q <= {addr_high_q, addr_low_q};
            wdata_q <= data_q;
          end
          else if (ext_wr_go)
          begin
            wst_q <= edwc_pkg::WR_ERASE;
            waddr_q <= s2_q[17:8];
            wdata_q <= s2_q[7:0];
          end
        end
        edwc_pkg::WR_ERASE:
        begin
          if (wcnt_q + 32'h0000_0001 >= PHASE_CYCLES)
          begin
            wst_q <= edwc_pkg::WR_PROG;
            wcnt_q <= 32'h0000_0000;
          end
          else
          begin
            wcnt_q <= wcnt_q + 32'h0000_0001;
          end
        end
        edwc_pkg::WR_PROG:
        begin
          if (wcnt_q + 32'h0000_0001 >= PHASE_CYCLES)
          begin
            wst_q <= edwc_pkg::WR_IDLE;
            wcnt_q <= 32'h0000_0000;
          end
          else
          begin
            wcnt_q <= wcnt_q + 32'h0000_0001;
          end
        end
        default: wst_q <= edwc_pkg::WR_IDLE;
      endcase
    end
  end
  assign done_pulse = (wst_q == edwc_pkg::WR_PROG) &&
                      (wcnt_q + 32'h0000_0001 >= PHASE_CYCLES);

  // The array is written once per phase: erased byte first, then data.
  assign mem_we = busy && (wcnt_q == 32'h0000_0000);
  assign mem_wdata = (wst_q == edwc_pkg::WR_ERASE) ? edwc_pkg::ERASED_BYTE
                                                   : wdata_q;
  assign mem_re = core_rd_go || ext_rd_go;
  assign mem_addr = busy ? waddr_q
                  : (core_rd_go ? {addr_high_q, addr_low_q}
                                : s2_q[17:8]);

  edwc_mem u_mem
  (
    .clk(CORE_CLK),
    .rst(RST),
    .we(mem_we),
    .re(mem_re),
    .addr(mem_addr),
    .wdata(mem_wdata),
    .rdata_q(mem_rdata)
  );

  // ----------------------------------------------------------------------
  // Address, data and control registers
  // ----------------------------------------------------------------------
  always_ff @(posedge CORE_CLK or posedge RST)
  begin
    if (RST)
    begin
      addr_high_q <= 2'h0;
      addr_low_q <= edwc_pkg::BYTE_RESET;
      data_q <= edwc_pkg::BYTE_RESET;
    end
    else
    begin
      if (hit(WB_ADR_I, edwc_pkg::OFS_ADDR_HIGH, wr_req) && !busy)
      begin
        addr_high_q <= WB_DAT_I[edwc_pkg::ADDR_HIGH_W-1:0];
      end
      if (hit(WB_ADR_I, edwc_pkg::OFS_ADDR_LOW, wr_req) && !busy)
      begin
        addr_low_q <= WB_DAT_I[7:0];
      end
      if (rd_q)
      begin
        data_q <= mem_rdata;
      end
      else if (hit(WB_ADR_I, edwc_pkg::OFS_DATA_BYTE, wr_req) && !busy)
      begin
        data_q <= WB_DAT_I[7:0];
      end
    end
  end

  // Bits without reset: the in-flight marker survives reset so an aborted
  // write can be reported, and the memory-select bits survive it so that
  // the error can be traced to the access that was running.
  always_ff @(posedge CORE_CLK)
  begin
    if (!RST)
    begin
      inflight_q <= busy;
      if (ctl_wr && !busy)
      begin
        sel_q <= WB_DAT_I[edwc_pkg::CTL_SELECT_BIT];
        cfgsel_q <= WB_DAT_I[edwc_pkg::CTL_CFGSEL_BIT];
      end
    end
  end

  // Control register; hardware only ever clears WR, RD and WERR, never WRITE_ENABLE_BIT.
  always_ff @(posedge CORE_CLK or posedge RST)
  begin
    if (RST)
    begin
      rowerase_q <= 1'b0;
      write_enable_bit_q <= 1'b0;
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      werr_q <= 1'b0;
      first_q <= 1'b1;
    end
    else
    begin
      first_q <= 1'b0;
      rd_q <= core_rd_go;
      if (ctl_wr && !busy)
      begin
        rowerase_q <= WB_DAT_I[edwc_pkg::CTL_ROWERASE_BIT];
        write_enable_bit_q <= WB_DAT_I[edwc_pkg::CTL_WRITE_ENABLE_BIT_BIT];
      end
      if (start)
      begin
        wr_q <= 1'b1;
      end
      else if (done_pulse)
      begin
        wr_q <= 1'b0;
      end
      if ((first_q && inflight_q == 1'b1) || (wr_try && !start))
      begin
        werr_q <= 1'b1;
      end
      else if (done_pulse)
      begin
        werr_q <= 1'b0;
      end
      else if (ctl_wr && !busy)
      begin
        werr_q <= WB_DAT_I[edwc_pkg::CTL_WERR_BIT];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Done flag, enables and interrupt requests
  // ----------------------------------------------------------------------
  // Completion beats a simultaneous software clear so no event is lost.
  always_ff @(posedge CORE_CLK or posedge RST)
  begin
    if (RST)
    begin
      done_q <= 1'b0;
      done_en_q <= 1'b0;
      done_prio_q <= 1'b0;
      gie_high_q <= 1'b0;
      gie_low_q <= 1'b0;
    end
    else
    begin
      if (done_pulse)
      begin
        done_q <= 1'b1;
      end
      else if (hit(WB_ADR_I, edwc_pkg::OFS_FLAGS_TWO, wr_req))
      begin
        done_q <= WB_DAT_I[edwc_pkg::DONE_BIT];
      end
      if (hit(WB_ADR_I, edwc_pkg::OFS_ENABLES_TWO, wr_req))
      begin
        done_en_q <= WB_DAT_I[edwc_pkg::DONE_BIT];
      end
      if (hit(WB_ADR_I, edwc_pkg::OFS_PRIORITY_TWO, wr_req))
      begin
        done_prio_q <= WB_DAT_I[edwc_pkg::DONE_BIT];
      end
      if (hit(WB_ADR_I, edwc_pkg::OFS_IRQ_GLOBAL, wr_req))
      begin
        gie_high_q <= WB_DAT_I[edwc_pkg::GIE_HIGH_BIT];
        gie_low_q <= WB_DAT_I[edwc_pkg::GIE_LOW_BIT];
      end
    end
  end

  // Registered requests; a low-priority request also needs the high enable.
  always_ff @(posedge CORE_CLK or posedge RST)
  begin
    if (RST)
    begin
      IRQ_HIGH <= 1'b0;
      IRQ_LOW <= 1'b0;
      WRITE_BUSY <= 1'b0;
    end
    else
    begin
      IRQ_HIGH <= done_q && done_en_q && done_prio_q && gie_high_q;
      IRQ_LOW <= done_q && done_en_q && !done_prio_q && gie_high_q &&
                 gie_low_q;
      WRITE_BUSY <= busy;
    end
  end

  // ----------------------------------------------------------------------
  // External programming port answers
  // ----------------------------------------------------------------------
  always_ff @(posedge CORE_CLK or posedge RST)
  begin
    if (RST)
    begin
      EXT_RDATA <= edwc_pkg::BYTE_RESET;
      EXT_DENIED <= 1'b0;
      ext_pend_q <= 1'b0;
    end
    else
    begin
      ext_pend_q <= ext_rd_go;
      if (ext_pend_q)
      begin
        EXT_RDATA <= mem_rdata;
      end
      if ((ext_rd_rise || ext_wr_rise) && prot_s)
      begin
        EXT_DENIED <= 1'b1;
      end
      else if (ext_rd_go || ext_wr_go)
      begin
        EXT_DENIED <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  sequence seq_core_read;
    core_rd_go ##1 rd_q;
  endsequence
  sequence seq_locked;
    busy [*2];
  endsequence

  chk_ack_single: assert property (@(posedge CORE_CLK) disable iff (RST)
    req |=> WB_ACK_O ##1 !WB_ACK_O)
    else $error("ack not a single cycle");
  chk_key_reads_zero: assert property (@(posedge CORE_CLK) disable iff (RST)
    rd_req && WB_ADR_I == edwc_pkg::OFS_UNLOCK_KEY |=> WB_DAT_O == 32'h0)
    else $error("key register read not zero");
  chk_start_unlocked: assert property (@(posedge CORE_CLK) disable iff (RST)
    $rose(wr_q) |-> $past(key_q) == edwc_pkg::KEY_ARMED)
    else $error("write started without unlock");
  chk_write_enable_bit_earlier: assert property (@(posedge CORE_CLK) disable iff (RST)
    $rose(wr_q) |-> $past(write_enable_bit_q) && write_enable_bit_q)
    else $error("write started without prior write enable");
  chk_write_enable_bit_kept: assert property (@(posedge CORE_CLK) disable iff (RST)
    write_enable_bit_q && !ctl_wr |=> write_enable_bit_q)
    else $error("write enable cleared by hardware");
  chk_lock_regs: assert property (@(posedge CORE_CLK) disable iff (RST)
    seq_locked |-> $stable(addr_low_q) && $stable(addr_high_q) &&
                   $stable(write_enable_bit_q) && $stable(data_q))
    else $error("registers changed during write");
  chk_done_sets: assert property (@(posedge CORE_CLK) disable iff (RST)
    done_pulse |=> done_q && !wr_q && !busy)
    else $error("completion did not set flag");
  chk_flag_sticky: assert property (@(posedge CORE_CLK) disable iff (RST)
    done_q && !hit(WB_ADR_I, edwc_pkg::OFS_FLAGS_TWO, wr_req) |=> done_q)
    else $error("done flag lost");
  chk_pwrt_block: assert property (@(posedge CORE_CLK) disable iff (RST)
    !pwrt_done_q |=> !busy)
    else $error("write during power-up timer");
  chk_read_next: assert property (@(posedge CORE_CLK) disable iff (RST)
    seq_core_read |=> !rd_q && data_q == $past(mem_rdata))
    else $error("read data not loaded");
  chk_erase_first: assert property (@(posedge CORE_CLK) disable iff (RST)
    $rose(busy) |-> wst_q == edwc_pkg::WR_ERASE ##1 $past(mem_we))
    else $error("write did not erase first");
  chk_ext_refused: assert property (@(posedge CORE_CLK) disable iff (RST)
    ext_rd_rise && prot_s |=> EXT_DENIED && !ext_pend_q)
    else $error("protected external read not refused");

endmodule : edwc_ctrl
`default_nettype wire

// [edwc_ext_prog.sv]
// External programmer model for the protected access port.
// Assumes it is clocked by the core clock that the block samples with.
`timescale 1ns/1ps
`default_nettype none
module edwc_ext_prog
(
  // Clock
  input wire logic clk,
  // Programming pins
  output logic rd,
  output logic wr,
  output logic [9:0] addr,
  output logic [7:0] wdata
);
  // Pins idle low from time zero.
  initial
  begin
    rd = 1'b0;
    wr = 1'b0;
    addr = 10'h000;
    wdata = 8'h00;
  end
  // Address is held well around the strobe edge, which the pins need.
  task automatic xfer(input logic w, input logic [9:0] a,
                      input logic [7:0] v);
    addr <= a;
    wdata <= v;
    repeat (4) @(posedge clk);
    rd <= !w;
    wr <= w;
    repeat (8) @(posedge clk);
    rd <= 1'b0;
    wr <= 1'b0;
    repeat (4) @(posedge clk);
    // Stale pins are inverted so that a late sample cannot pass by luck.
    addr <= ~a;
    wdata <= ~wdata;
  endtask : xfer
endmodule : edwc_ext_prog
`default_nettype wire

// [edwc_ctrl_bench.sv]
// Self-checking bench for the write-control block with short timers.
// Assumes the block's Wishbone slave answers within a few cycles.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin \
  mismatches++; $display("unexpected at %0t: %h not %h", $time, a, b); end end
module edwc_ctrl_bench;
  logic clk = 1'b0, rst = 1'b1, cyc = 1'b0, we = 1'b0, prot = 1'b0;
  logic [7:0] adr = 8'h00, rv, d;
  logic [31:0] wdat = 32'h0, dato, s = 32'd94;
  logic ack, irqh, irql, busy, erd, ewr;
  logic [9:0] eadr, a;
  logic [7:0] ewd, erdat;
  logic eden;
  int mismatches = 0, samples_checked = 0;
  edwc_ctrl #(.WRITE_CYCLES(8), .PWRT_CYCLES(16)) dut (.CORE_CLK(clk),
    .RST(rst), .WB_CYC_I(cyc), .WB_STB_I(cyc), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_SEL_I(4'h1), .WB_DAT_I(wdat), .WB_DAT_O(dato),
    .WB_ACK_O(ack), .IRQ_HIGH(irqh), .IRQ_LOW(irql), .CODE_PROTECT(prot),
    .EXT_RD(erd), .EXT_WR(ewr), .EXT_ADDR(eadr), .EXT_WDATA(ewd),
    .EXT_RDATA(erdat), .EXT_DENIED(eden), .WRITE_BUSY(busy));
  edwc_ext_prog prog (.clk(clk), .rd(erd), .wr(ewr), .addr(eadr),
    .wdata(ewd));
  // Clock of 8 ns.
  always #4 clk = ~clk;
  // Expected control byte from the error and write-enable bits.
  function automatic logic [7:0] ctl(logic e, logic w);
    return {4'h0, e, w, 2'b00};
  endfunction : ctl
  // Xorshift source; fixed seed keeps runs repeatable.
  function automatic logic [31:0] rnd();
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : rnd
  // One classic cycle, held until the edge that samples ack high.
  task automatic wb(input logic w, input logic [7:0] ad, input logic [7:0] v);
    cyc <= 1'b1;
    we <= w;
    adr <= ad;
    wdat <= {24'h0, v};
    do @(posedge clk); while (ack !== 1'b1);
    rv = dato[7:0];
    cyc <= 1'b0;
    @(posedge clk);
  endtask : wb
  // Unlock keys, then the control write that asks for a start.
  task automatic go(input logic [7:0] k1, k2, c);
    wb(1, edwc_pkg::OFS_UNLOCK_KEY, k1);
    wb(1, edwc_pkg::OFS_UNLOCK_KEY, k2);
    wb(1, edwc_pkg::OFS_ACCESS_CTRL, c);
    repeat (2) @(posedge clk);
    for (int n = 0; n < 100 && busy !== 1'b0; n++) @(posedge clk);
  endtask : go
  // Ends the run with the counts and the verdict.
  task automatic give_verdict();
    $display("mismatches %0d checked %0d", mismatches, samples_checked);
    if (mismatches == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : give_verdict
  // Watchdog, far beyond the expected run length.
  initial
  begin
    #200000;
    mismatches++;
    give_verdict();
  end
  // Main sequence.
  initial
  begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    wb(0, edwc_pkg::OFS_ACCESS_CTRL, 0); `CHK(rv[2], 1'b0)
    wb(0, edwc_pkg::OFS_UNLOCK_KEY, 0); `CHK(rv, 8'h00)
    wb(1, edwc_pkg::OFS_ADDR_HIGH, 8'hFF);
    wb(0, edwc_pkg::OFS_ADDR_HIGH, 0); `CHK(rv, 8'h03)
    wb(1, edwc_pkg::OFS_ENABLES_TWO, 8'h10);
    wb(1, edwc_pkg::OFS_PRIORITY_TWO, 8'h10);
    wb(1, edwc_pkg::OFS_IRQ_GLOBAL, 8'h80);
    repeat (20) @(posedge clk);
    for (int i = 0; i < 4; i++)
    begin
      void'(rnd());
      a = s[17:8];
      d = s[7:0];
      wb(1, edwc_pkg::OFS_ADDR_HIGH, {6'h3F, a[9:8]});
      wb(1, edwc_pkg::OFS_ADDR_LOW, a[7:0]);
      wb(1, edwc_pkg::OFS_DATA_BYTE, d);
      wb(1, edwc_pkg::OFS_ACCESS_CTRL, ctl(0, 1));
      wb(1, edwc_pkg::OFS_UNLOCK_KEY, edwc_pkg::KEY_FIRST);
      wb(1, edwc_pkg::OFS_UNLOCK_KEY, edwc_pkg::KEY_SECOND);
      wb(1, edwc_pkg::OFS_ACCESS_CTRL, ctl(0, 1) | 8'h02);
      // Both writes land while the write runs and must be ignored.
      wb(1, edwc_pkg::OFS_DATA_BYTE, ~d);
      wb(1, edwc_pkg::OFS_ACCESS_CTRL, 8'h00);
      for (int n = 0; n < 100 && busy !== 1'b0; n++) @(posedge clk);
      wb(0, edwc_pkg::OFS_DATA_BYTE, 0); `CHK(rv, d)
      wb(0, edwc_pkg::OFS_ACCESS_CTRL, 0); `CHK(rv, ctl(0, 1))
      wb(0, edwc_pkg::OFS_FLAGS_TWO, 0); `CHK(rv, 8'h10)
      `CHK(irqh, 1'b1)
      wb(1, edwc_pkg::OFS_FLAGS_TWO, 0);
      wb(0, edwc_pkg::OFS_FLAGS_TWO, 0); `CHK(rv, 8'h00)
      void'(rnd());
      prot <= s[0];
      wb(1, edwc_pkg::OFS_DATA_BYTE, 0);
      wb(1, edwc_pkg::OFS_ACCESS_CTRL, ctl(0, 1) | 8'h01);
      wb(0, edwc_pkg::OFS_DATA_BYTE, 0); `CHK(rv, d)
    end
    go(8'hAA, 8'h55, ctl(0, 1) | 8'h02);
    wb(0, edwc_pkg::OFS_ACCESS_CTRL, 0); `CHK(rv, ctl(1, 1))
    wb(1, edwc_pkg::OFS_ACCESS_CTRL, 0);
    go(8'h55, 8'hAA, 8'h02);
    go(8'h55, 8'hAA, ctl(0, 1) | 8'h02);
    wb(0, edwc_pkg::OFS_FLAGS_TWO, 0); `CHK(rv, 8'h00)
    // External port: refused while protected, served once it is lifted.
    prot <= 1'b1;
    prog.xfer(1, a, ~d);
    `CHK(eden, 1'b1)
    prog.xfer(0, a, 8'h00);
    `CHK(eden, 1'b1)
    prot <= 1'b0;
    prog.xfer(0, a, 8'h00);
    `CHK(eden, 1'b0)
    `CHK(erdat, d)
    prog.xfer(1, a, ~d);
    for (int n = 0; n < 100 && busy !== 1'b0; n++) @(posedge clk);
    prog.xfer(0, a, 8'h00);
    `CHK(erdat, ~d)
    // The completion flag of the external write now asks at low priority.
    wb(1, edwc_pkg::OFS_PRIORITY_TWO, 8'h00);
    wb(1, edwc_pkg::OFS_IRQ_GLOBAL, 8'hC0);
    `CHK(irql, 1'b1)
    `CHK(irqh, 1'b0)
    // A reset in mid-write must leave the error flag set afterwards.
    wb(1, edwc_pkg::OFS_UNLOCK_KEY, edwc_pkg::KEY_FIRST);
    wb(1, edwc_pkg::OFS_UNLOCK_KEY, edwc_pkg::KEY_SECOND);
    wb(1, edwc_pkg::OFS_ACCESS_CTRL, ctl(0, 1) | 8'h02);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (20) @(posedge clk);
    wb(0, edwc_pkg::OFS_ACCESS_CTRL, 0); `CHK(rv, ctl(1, 0))
    give_verdict();
  end
endmodule : edwc_ctrl_bench
`default_nettype wire
